// file: rtl/tape_cmp_defs.vh
// constants for the punched-tape comparator control block
`ifndef TAPE_CMP_DEFS_VH
`define TAPE_CMP_DEFS_VH

// ==========================================
// timing
`define CLK_MHZ          100
`define DEB_TIME_US      5000
`define DEB_CNT_W        19
// 5 ms of stable input at 100 MHz
`define DEB_CYCLES_DFLT  19'd500000

// ==========================================
// register offsets (byte addresses)
`define OFS_CTRL         12'h000
`define OFS_DISC         12'h004
`define OFS_STATUS       12'h008
`define OFS_CODES        12'h00c

// ==========================================
// control register fields
`define CTRL_TWIN        0
`define CTRL_WIDE        1
`define CTRL_WSEL_LO     2
`define CTRL_WSEL_HI     3
`define CTRL_SKIP1       4
`define CTRL_SKIP2       5
`define CTRL_FEED_EN     6
`define CTRL_DEL_EN      7
`define CTRL_CUST_EN     8
`define CTRL_W           9
`define CTRL_RST         9'h0d0

// ==========================================
// status register fields
`define ST_RUN           0
`define ST_MISMATCH      1
`define ST_NOTAPE1       2
`define ST_NOTAPE2       3
`define ST_STATE_LO      4
`define ST_STATE_HI      6

// ==========================================
// reset values
`define DISC_RST         16'h0000
`define CODE_RST         16'h0000

`endif

// file: rtl/tape_cmp_ctrl.v
// punched-tape comparator control with apb registers
`timescale 1ns/1ps
`include "tape_cmp_defs.vh"

// ==========================================
// input synchroniser and debouncer
module sync_debounce #(
  parameter [`DEB_CNT_W-1:0] CYCLES = 19'd1
) (
  input  wire pclk,
  input  wire presetn,
  input  wire raw,
  output reg  clean_q
);
  reg                  s1_q;
  reg                  s2_q;
  reg [`DEB_CNT_W-1:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      cnt_q   <= {`DEB_CNT_W{1'b0}};
      clean_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      if (s2_q == clean_q) begin
        cnt_q <= {`DEB_CNT_W{1'b0}};
      end else if (cnt_q >= CYCLES - 19'd1) begin
        cnt_q   <= {`DEB_CNT_W{1'b0}};
        clean_q <= s2_q;
      end else begin
        cnt_q <= cnt_q + 19'd1;
      end
    end
  end
endmodule // sync_debounce

module tape_cmp_ctrl #(
  parameter [`DEB_CNT_W-1:0] DEB_CYCLES = `DEB_CYCLES_DFLT
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        start_sw,
  input  wire        stop_sw,
  input  wire        no_tape1,
  input  wire        no_tape2,
  output reg         step1,
  output reg         step2,
  input  wire        reader1_busy,
  input  wire        reader2_busy,
  input  wire        reader_cycle_contact1,
  input  wire        reader_cycle_contact2,
  input  wire [15:0] code1,
  input  wire [15:0] code2,
  output wire        error_lamp,
  output wire        run_lamp
);

  // ==========================================
  // state codes
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ARM  = 3'h1;
  localparam [2:0] S_STEP = 3'h2;
  localparam [2:0] S_WAIT = 3'h3;
  localparam [2:0] S_CMP  = 3'h4;

  // ==========================================
  // declarations
  reg  [`CTRL_W-1:0] ctrl_q;
  reg  [15:0]        disc_q;
  reg  [15:0]        last1_q;
  reg  [15:0]        last2_q;
  reg                run_latch_q;
  reg                mismatch_latch_q;
  reg                begun_q;
  reg                single_q;
  reg                start_prev_q;
  reg  [2:0]         state_q;
  reg  [2:0]         state_d;
  reg                want1_q;
  reg                want2_q;
  reg                done1_q;
  reg                done2_q;
  reg                nxt1;
  reg                nxt2;
  reg                set_err;
  reg  [15:0]        mask;
  reg  [31:0]        rd_mux;
  reg                rd_ok;
  wire               start_db;
  wire               stop_db;
  wire               nt1_db;
  wire               nt2_db;
  wire               start_edge;
  wire               tape_ok;
  wire [15:0]        m1;
  wire [15:0]        m2;
  wire               disc1;
  wire               disc2;
  wire               acc;
  wire               wr;
  wire               twin;

  // ==========================================
  // operator and tape-sensor inputs
  // debounced inputs
  sync_debounce #(.CYCLES(DEB_CYCLES)) u_start (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (start_sw),
    .clean_q (start_db)
  );
  sync_debounce #(.CYCLES(DEB_CYCLES)) u_stop (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (stop_sw),
    .clean_q (stop_db)
  );
  sync_debounce #(.CYCLES(DEB_CYCLES)) u_nt1 (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (no_tape1),
    .clean_q (nt1_db)
  );
  sync_debounce #(.CYCLES(DEB_CYCLES)) u_nt2 (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (no_tape2),
    .clean_q (nt2_db)
  );

  assign start_edge = start_db & ~start_prev_q;
  assign tape_ok    = ~nt1_db & ~nt2_db;
  assign twin       = ctrl_q[`CTRL_TWIN];

  // ==========================================
  // code masking and discard detection
  // level mask
  always @* begin
    case (ctrl_q[`CTRL_WSEL_HI:`CTRL_WSEL_LO])
      2'h0:    mask = 16'h001f;
      2'h1:    mask = 16'h003f;
      2'h2:    mask = 16'h007f;
      default: mask = 16'h00ff;
    endcase
    if (twin && ctrl_q[`CTRL_WIDE]) begin
      mask = 16'hffff;
    end
  end

  assign m1 = code1 & mask;
  assign m2 = code2 & mask;

  assign disc1 = (ctrl_q[`CTRL_FEED_EN] && m1 == 16'h0000) ||
                 (ctrl_q[`CTRL_DEL_EN] && m1 == mask) ||
                 (ctrl_q[`CTRL_CUST_EN] && m1 == (disc_q & mask));
  assign disc2 = (ctrl_q[`CTRL_FEED_EN] && m2 == 16'h0000) ||
                 (ctrl_q[`CTRL_DEL_EN] && m2 == mask) ||
                 (ctrl_q[`CTRL_CUST_EN] && m2 == (disc_q & mask));

  // ==========================================
  // comparison decision
  always @* begin
    nxt1    = 1'b1;
    nxt2    = 1'b1;
    set_err = 1'b0;
    if (m1 != m2) begin
      if (!twin) begin
        set_err = 1'b1;
      end else if (ctrl_q[`CTRL_SKIP1] && disc1) begin
        nxt2 = 1'b0;
      end else if (ctrl_q[`CTRL_SKIP2] && disc2) begin
        nxt1 = 1'b0;
      end else begin
        set_err = 1'b1;
      end
    end
  end

  // ==========================================
  // sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (start_edge) begin
          state_d = S_ARM;
        end
      end
      S_ARM: begin
        if (!run_latch_q) begin
          state_d = S_IDLE;
        end else if (!start_db) begin
          state_d = S_STEP;
        end
      end
      S_STEP: begin
        state_d = run_latch_q ? S_WAIT : S_IDLE;
      end
      S_WAIT: begin
        if (done1_q && done2_q) begin
          state_d = S_CMP;
        end
      end
      S_CMP: begin
        if (set_err || !run_latch_q) begin
          state_d = S_IDLE;
        end else begin
          state_d = S_STEP;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= S_IDLE;
      start_prev_q     <= 1'b0;
      run_latch_q      <= 1'b0;
      mismatch_latch_q <= 1'b0;
      begun_q          <= 1'b0;
      single_q         <= 1'b0;
      want1_q          <= 1'b1;
      want2_q          <= 1'b1;
      done1_q          <= 1'b0;
      done2_q          <= 1'b0;
      step1            <= 1'b0;
      step2            <= 1'b0;
      last1_q          <= `CODE_RST;
      last2_q          <= `CODE_RST;
    end else begin
      start_prev_q <= start_db;
      state_q      <= state_d;
      step1        <= 1'b0;
      step2        <= 1'b0;

      if (state_q == S_STEP) begin
        step1   <= want1_q & run_latch_q;
        step2   <= want2_q & run_latch_q;
        done1_q <= ~want1_q;
        done2_q <= ~want2_q;
      end else begin
        if (reader_cycle_contact1) begin
          done1_q <= 1'b1;
        end
        if (reader_cycle_contact2) begin
          done2_q <= 1'b1;
        end
      end

      if (state_q != S_WAIT) begin
        begun_q <= 1'b0;
      end else if (reader1_busy || reader2_busy) begin
        begun_q <= 1'b1;
      end

      if (state_q == S_CMP) begin
        last1_q <= m1;
        last2_q <= m2;
        want1_q <= nxt1;
        want2_q <= nxt2;
      end

      if (state_q == S_CMP && set_err) begin
        mismatch_latch_q <= 1'b1;
      end else if (start_edge) begin
        mismatch_latch_q <= 1'b0;
      end

      if (start_edge) begin
        single_q <= stop_db;
      end

      if (state_q == S_CMP && set_err) begin
        run_latch_q <= 1'b0;
      end else if (start_edge) begin
        run_latch_q <= tape_ok;
      end else if (!tape_ok) begin
        run_latch_q <= 1'b0;
      end else if (stop_db && !start_db) begin
        if (!single_q || begun_q || reader1_busy || reader2_busy) begin
          run_latch_q <= 1'b0;
        end
      end
    end
  end

  assign error_lamp = mismatch_latch_q;
  assign run_lamp   = run_latch_q;

  // ==========================================
  // apb slave
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign pready  = 1'b1;
  assign pslverr = acc & ~rd_ok;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (paddr)
      `OFS_CTRL: begin
        rd_mux[`CTRL_W-1:0] = ctrl_q;
      end
      `OFS_DISC: begin
        rd_mux[15:0] = disc_q;
      end
      `OFS_STATUS: begin
        rd_mux[`ST_RUN]      = run_latch_q;
        rd_mux[`ST_MISMATCH] = mismatch_latch_q;
        rd_mux[`ST_NOTAPE1]  = nt1_db;
        rd_mux[`ST_NOTAPE2]  = nt2_db;
        rd_mux[`ST_STATE_HI:`ST_STATE_LO] = state_q;
      end
      `OFS_CODES: begin
        rd_mux = {last2_q, last1_q};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
      disc_q <= `DISC_RST;
      prdata <= 32'h0000_0000;
    end else begin
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
      if (wr && paddr == `OFS_CTRL) begin
        ctrl_q <= pwdata[`CTRL_W-1:0];
      end
      if (wr && paddr == `OFS_DISC) begin
        disc_q <= pwdata[15:0];
      end
    end
  end

endmodule // tape_cmp_ctrl

// file: bench/tape_cmp_sva.sv
// port checker for the tape comparator control
`timescale 1ns/1ps
module tape_cmp_sva #(parameter DEB_CYCLES = 2) (
  input wire pclk,
  input wire presetn,
  input wire start_sw,
  input wire stop_sw,
  input wire no_tape1,
  input wire no_tape2,
  input wire step1,
  input wire step2,
  input wire reader1_busy,
  input wire error_lamp,
  input wire run_lamp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // sequences
  sequence s_stop_held;
    stop_sw [*8];
  endsequence
  sequence s_begun;
    $rose(reader1_busy);
  endsequence
  sequence s_no_start;
    (!start_sw) [*8];
  endsequence
  // ==========
  // properties
  a_err_no_step: assert property (error_lamp |-> !step1 && !step2)
    else $error("step while error latched");
  a_step_pulse: assert property (step1 || step2 |=> !step1 && !step2)
    else $error("step longer than one cycle");
  a_step_needs_run: assert property (step1 || step2 |-> $past(run_lamp))
    else $error("step without run latch");
  a_err_kills_run: assert property ($rose(error_lamp) |-> ##[0:1] !run_lamp)
    else $error("run latch kept after mismatch");
  a_err_holds: assert property (s_no_start ##1 error_lamp |=> error_lamp)
    else $error("error lamp cleared without start");
  a_single_drop: assert property (s_stop_held ##0 s_begun |-> ##[0:3] !run_lamp)
    else $error("run latch kept in single step");
  a_notape_stop: assert property (no_tape1 [*8] ##1 no_tape1 |-> !run_lamp)
    else $error("run latch kept without tape");
  a_start_runs: assert property ((start_sw && !stop_sw && !no_tape1 && !no_tape2) [*8] ##1 1'b1 |-> run_lamp)
    else $error("start did not set run latch");
endmodule // tape_cmp_sva

bind tape_cmp_ctrl tape_cmp_sva #(.DEB_CYCLES(DEB_CYCLES)) sva_u (
  .pclk, .presetn, .start_sw, .stop_sw, .no_tape1, .no_tape2,
  .step1, .step2, .reader1_busy, .error_lamp, .run_lamp);

// file: bench/tape_reader_model.sv
// behavioural punched-tape reader
`timescale 1ns/1ps
module tape_reader_model #(parameter int DLY = 3) (
  input  wire logic        clk,
  input  wire logic        step,
  output logic             busy,
  output logic             contact,
  output logic             no_tape,
  output logic      [15:0] code
);
  logic [15:0] tape [0:31];
  int          pos = 0;
  int          len = 0;
  int          cnt = 0;

  task automatic load(input int n);
    pos = 0;
    len = n;
    busy = 1'b0;
    contact = 1'b0;
    for (int i = 0; i < 32; i++) tape[i] = 16'(i) + 16'h0040;
  endtask

  always @(posedge clk) begin
    contact <= 1'b0;
    if (step && !busy) begin
      busy <= 1'b1;
      cnt <= DLY;
    end else if (busy && cnt > 1) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      busy <= 1'b0;
      pos <= pos + 1;
      contact <= 1'b1;
    end
  end

  assign code = busy ? ~tape[pos] : tape[pos];
  assign no_tape = pos >= len;
endmodule // tape_reader_model

// file: bench/paper_tape_comparator_control_bench.sv
// self-checking bench for the tape comparator control
`timescale 1ns/1ps
module paper_tape_comparator_control_bench;
  logic        pclk, presetn, psel, penable, pwrite, start_sw, stop_sw, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  wire         pready, pslverr, step1, step2, no_tape1, no_tape2, error_lamp, run_lamp;
  wire         reader1_busy, reader2_busy, reader_cycle_contact1, reader_cycle_contact2;
  wire  [31:0] prdata;
  wire  [15:0] code1, code2;
  int          err_count = 0;
  int          n_tests = 0;

  tape_cmp_ctrl #(.DEB_CYCLES(19'd2)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .start_sw, .stop_sw, .no_tape1, .no_tape2, .step1, .step2, .reader1_busy, .reader2_busy,
    .reader_cycle_contact1, .reader_cycle_contact2, .code1, .code2, .error_lamp, .run_lamp);
  tape_reader_model #(.DLY(3)) r1_u (.clk(pclk), .step(step1), .busy(reader1_busy),
    .contact(reader_cycle_contact1), .no_tape(no_tape1), .code(code1));
  tape_reader_model #(.DLY(6)) r2_u (.clk(pclk), .step(step2), .busy(reader2_busy),
    .contact(reader_cycle_contact2), .no_tape(no_tape2), .code(code2));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========
  // shared tasks
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic prep(input logic [31:0] c, input int n);
    apb(1'b1, 12'h000, c);
    r1_u.load(n);
    r2_u.load(n);
    repeat (12) @(posedge pclk);
  endtask

  task automatic press;
    start_sw <= 1'b1;
    repeat (8) @(posedge pclk);
    start_sw <= 1'b0;
    repeat (20) @(posedge pclk);
    while (run_lamp === 1'b1) @(posedge pclk);
    repeat (20) @(posedge pclk);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_reset", rdata, 32'h0000_00d0);
    apb(1'b1, 12'h004, 32'h0000_1357);
    apb(1'b0, 12'h004, 32'h0);
    chk("disc", rdata, 32'h0000_1357);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", rerr, 32'h1);
    $display("done regs");
  endtask

  task automatic t_dual;
    prep(32'h0cc, 8);
    r1_u.tape[2] = 16'h0000;
    r2_u.tape[2] = 16'h0000;
    r1_u.tape[5] = 16'h0000;
    press;
    chk("dual_err", error_lamp, 32'h1);
    chk("dual_pos1", r1_u.pos, 32'd5);
    chk("dual_pos2", r2_u.pos, 32'd5);
    apb(1'b0, 12'h00c, 32'h0);
    chk("codes", rdata, 32'h0045_0000);
    apb(1'b0, 12'h008, 32'h0);
    chk("status", rdata[1:0], 32'h2);
    r2_u.tape[5] = 16'h0000;
    press;
    chk("resume_err", error_lamp, 32'h0);
    chk("resume_end", r1_u.pos >= 8 && r1_u.pos == r2_u.pos, 32'h1);
    $display("done dual");
  endtask

  task automatic t_width;
    for (int w = 0; w < 4; w++) begin
      prep(32'h0c0 | (w << 2), 6);
      r2_u.tape[3] ^= 16'h1 << (5 + w);
      r2_u.tape[4] ^= 16'h1 << (4 + w);
      press;
      chk("width_pos", r1_u.pos, 32'd4);
      chk("width_err", error_lamp, 32'h1);
    end
    $display("done width");
  endtask

  task automatic t_skip(input logic [31:0] c, input logic [15:0] d0, input logic [15:0] d1);
    prep(c, 10);
    r1_u.tape[3] = d0;
    r1_u.tape[4] = d1;
    for (int i = 3; i < 29; i++) r2_u.tape[i] = r1_u.tape[i + 2];
    r2_u.len = 8;
    press;
    chk("skip_err", error_lamp, 32'h0);
    chk("skip_gap", r1_u.pos - r2_u.pos, 32'd2);
    $display("done skip");
  endtask

  task automatic t_skip2;
    prep(32'h0ed, 10);
    r2_u.tape[3] = 16'h00ff;
    for (int i = 4; i < 29; i++) r2_u.tape[i] = r1_u.tape[i - 1];
    r1_u.len = 8;
    press;
    chk("skip2_err", error_lamp, 32'h0);
    chk("skip2_gap", r2_u.pos - r1_u.pos, 32'd1);
    $display("done skip2");
  endtask

  task automatic t_extra;
    prep(32'h0dd, 8);
    for (int i = 28; i > 3; i--) r2_u.tape[i] = r2_u.tape[i - 1];
    r2_u.tape[3] = 16'h00ff;
    press;
    chk("extra_err", error_lamp, 32'h1);
    chk("extra_pos", r2_u.pos, 32'd3);
    $display("done extra");
  endtask

  task automatic t_single;
    prep(32'h0cc, 8);
    r2_u.tape[2] = 16'h0011;
    stop_sw <= 1'b1;
    repeat (12) @(posedge pclk);
    for (int k = 1; k < 4; k++) begin
      press;
      chk("single_pos", r1_u.pos, k);
      chk("single_err", error_lamp, k == 2);
    end
    stop_sw <= 1'b0;
    $display("done single");
  endtask

  // ==========
  // main sequence and watchdog
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    start_sw = 1'b0;
    stop_sw = 1'b0;
    r1_u.load(0);
    r2_u.load(0);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_dual;
    t_width;
    t_skip(32'h0dd, 16'h0000, 16'h00ff);
    t_skip(32'h1d3, 16'hffff, 16'h1357);
    t_skip2;
    t_extra;
    t_single;
    summarize;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    summarize;
  end
endmodule // paper_tape_comparator_control_bench
